/* logic/hspp_host_port.sv */
/*
  Host strobe port of the scan test master together with the output
  enable handling of the scan-master chain pins and the test clock divider.
  Assumes an internal access client that answers a read request with data
  on acc_rdata_i in the same cycle as acc_rd_o, and a scan engine that drives
  the chain_* source levels. Three-state pins are split into value and
  active-low enable; the pad ring resolves the wire.
*/

// Functional notes
// - Acknowledge is driven low once the cycle's data is captured and released after the cycle.
// - With chip enable high the data bus and acknowledge float; with it low the port works.
// - Select high requests a read and low requests a write.
// - Each transfer is framed by the low strobe, with inputs held until it rises.
// - The data bus floats whenever the strobe is high, 16 or 32 bits wide.
// - Upper data bits and the second chain reset exist only in the wide build.
// - Reset low initialises all state without waiting for the clock.
// - The float flag is high exactly while chain data out floats.
// - The device test data output is driven only while output enable is low.
// - Output enable high floats every chain output.
// - The chain test clock is a gated division of the system clock.
module hspp_host_port #(
  parameter int unsigned DATA_W  = hspp_pkg::NARROW_DATA_W,
  parameter int unsigned TCK_DIV = hspp_pkg::TCK_DIV_DEF
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      nrst_i,
  input  wire logic                      host_ce_n_i,
  input  wire logic                      host_strobe_n_i,
  input  wire logic                      host_rw_i,
  input  wire logic [hspp_pkg::ADDR_W-1:0] host_addr_i,
  input  wire logic [DATA_W-1:0]         host_data_i,
  output logic      [DATA_W-1:0]         host_data_o,
  output logic                           host_data_oe_n_o,
  output logic                           transfer_ack_n_o,
  output logic                           transfer_ack_oe_n_o,
  output logic                           acc_wr_o,
  output logic                           acc_rd_o,
  output logic      [hspp_pkg::ADDR_W-1:0] acc_addr_o,
  output logic      [DATA_W-1:0]         acc_wdata_o,
  input  wire logic [DATA_W-1:0]         acc_rdata_i,
  input  wire logic                      out_en_n_i,
  input  wire logic                      dev_tdo_i,
  output logic                           dev_tdo_o,
  output logic                           dev_tdo_oe_n_o,
  input  wire logic                      scan_tdo_i,
  input  wire logic                      scan_tdo_en_i,
  input  wire logic                      scan_tms_i,
  input  wire logic                      scan_trst_i,
  input  wire logic                      scan_tck_run_i,
  output logic                           scan_tck_rise_o,
  output logic                           scan_tdi_o,
  input  wire logic                      chain_data_in_i,
  output logic                           chain_data_out_o,
  output logic                           chain_data_out_oe_n_o,
  output logic                           chain_mode_select_o,
  output logic                           chain_mode_select_oe_n_o,
  output logic                           chain_test_clock_o,
  output logic                           chain_test_clock_oe_n_o,
  output logic                           chain_test_reset_a_o,
  output logic                           chain_test_reset_a_oe_n_o,
  output logic                           chain_test_reset_b_o,
  output logic                           chain_test_reset_b_oe_n_o,
  output logic                           chain_out_float_flag_o
);

  localparam int unsigned NSYNC = 5;
  localparam int unsigned CNT_W = (TCK_DIV > 1) ? $clog2(TCK_DIV) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TCK_DIV - 1);
  localparam bit WIDE = (DATA_W == hspp_pkg::WIDE_DATA_W);

  // Pin synchronisers: ce, strobe, rw, out_en, chain_data_in
  logic [NSYNC-1:0] pin_raw;
  logic [hspp_pkg::SYNC_STAGES-1:0] sync_q [NSYNC];
  logic [NSYNC-1:0] filt_q;
  logic [NSYNC-1:0] next_filt;
  logic [hspp_pkg::SYNC_STAGES-1:0] next_sync [NSYNC];

  assign pin_raw = {chain_data_in_i, out_en_n_i, host_rw_i, host_strobe_n_i, host_ce_n_i};

  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_comb begin
      next_sync[g] = {sync_q[g][hspp_pkg::SYNC_STAGES-2:0], pin_raw[g]};
      // A change counts only once the second and third stage agree
      next_filt[g] = (sync_q[g][1] == sync_q[g][2]) ? sync_q[g][2] : filt_q[g];
    end
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        sync_q[g] <= hspp_pkg::SYNC_IDLE_LVL;
        filt_q[g] <= 1'b1;
      end else begin
        sync_q[g] <= next_sync[g];
        filt_q[g] <= next_filt[g];
      end
    end
  end

  logic ce_n_f;
  logic strobe_n_f;
  logic rw_f;
  logic oe_n_f;
  assign ce_n_f     = filt_q[0];
  assign strobe_n_f = filt_q[1];
  assign rw_f       = filt_q[2];
  assign oe_n_f     = filt_q[3];
  assign scan_tdi_o = filt_q[4];

  // Host cycle sequencer
  hspp_pkg::hspp_state_t state;
  hspp_pkg::hspp_state_t next_state;
  logic                        is_read;
  logic                        next_is_read;
  logic [DATA_W-1:0]           rdata;
  logic [DATA_W-1:0]           next_rdata;
  logic [hspp_pkg::ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0]           next_wdata;
  logic                        next_wr;
  logic                        next_rd;

  always_comb begin
    next_state   = state;
    next_is_read = is_read;
    next_rdata   = rdata;
    next_addr    = acc_addr_o;
    next_wdata   = acc_wdata_o;
    next_wr      = 1'b0;
    next_rd      = 1'b0;
    case (state)
      hspp_pkg::HSPP_IDLE: begin
        // Ce may stay low between cycles; any low strobe with ce low starts one, fresh or held
        if (!ce_n_f && !strobe_n_f) begin
          next_addr    = host_addr_i;
          next_is_read = rw_f;
          if (rw_f) begin
            next_rd    = 1'b1;
            next_state = hspp_pkg::HSPP_RD_WAIT;
          end else begin
            next_wdata = host_data_i;
            next_wr    = 1'b1;
            next_state = hspp_pkg::HSPP_ACK;
          end
        end
      end
      hspp_pkg::HSPP_RD_WAIT: begin
        next_rdata = acc_rdata_i;
        next_state = hspp_pkg::HSPP_ACK;
      end
      hspp_pkg::HSPP_ACK: begin
        // Cycle ends on strobe rise or deselect; ack is then released
        if (strobe_n_f || ce_n_f) begin
          next_state = hspp_pkg::HSPP_IDLE;
        end
      end
      default: begin
        next_state = hspp_pkg::HSPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state       <= hspp_pkg::HSPP_IDLE;
      is_read     <= 1'b0;
      rdata       <= '0;
      acc_addr_o  <= '0;
      acc_wdata_o <= '0;
      acc_wr_o    <= 1'b0;
      acc_rd_o    <= 1'b0;
    end else begin
      state       <= next_state;
      is_read     <= next_is_read;
      rdata       <= next_rdata;
      acc_addr_o  <= next_addr;
      acc_wdata_o <= next_wdata;
      acc_wr_o    <= next_wr;
      acc_rd_o    <= next_rd;
    end
  end

  logic in_ack;
  assign in_ack = (state == hspp_pkg::HSPP_ACK);

  // Raw pins gate the drivers so the bus floats at once, not four cycles late
  assign transfer_ack_n_o    = ~in_ack;
  assign transfer_ack_oe_n_o = host_ce_n_i | ~in_ack;
  assign host_data_o         = rdata;
  assign host_data_oe_n_o    = host_ce_n_i | host_strobe_n_i | ~(in_ack & is_read);

  // Test clock divider; clock parks low while the engine does not run it
  logic [CNT_W-1:0] div_cnt;
  logic [CNT_W-1:0] next_div_cnt;
  logic             tck;
  logic             next_tck;
  logic             tick;

  always_comb begin
    tick         = (div_cnt == CNT_LAST);
    next_div_cnt = tick ? '0 : div_cnt + CNT_W'(1);
    next_tck     = tck;
    if (tick) begin
      next_tck = scan_tck_run_i ? ~tck : 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= '0;
      tck     <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tck     <= next_tck;
    end
  end

  assign scan_tck_rise_o = tick & scan_tck_run_i & ~tck;

  // Registered chain outputs
  logic tdo_q;
  logic tms_q;
  logic trst_q;
  logic tdo_en_q;
  logic dev_tdo_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tdo_q     <= 1'b0;
      tms_q     <= 1'b1;
      trst_q    <= 1'b0;
      tdo_en_q  <= 1'b0;
      dev_tdo_q <= 1'b0;
    end else begin
      tdo_q     <= scan_tdo_i;
      tms_q     <= scan_tms_i;
      trst_q    <= scan_trst_i;
      tdo_en_q  <= scan_tdo_en_i;
      dev_tdo_q <= dev_tdo_i;
    end
  end

  assign chain_data_out_o         = tdo_q;
  assign chain_data_out_oe_n_o    = oe_n_f | ~tdo_en_q;
  assign chain_mode_select_o      = tms_q;
  assign chain_mode_select_oe_n_o = oe_n_f;
  assign chain_test_clock_o       = tck;
  assign chain_test_clock_oe_n_o  = oe_n_f;
  assign chain_test_reset_a_o     = trst_q;
  assign chain_test_reset_a_oe_n_o = oe_n_f;
  assign chain_out_float_flag_o   = chain_data_out_oe_n_o;
  assign dev_tdo_o                = dev_tdo_q;
  assign dev_tdo_oe_n_o           = oe_n_f;

  // Narrow build has no second reset pin: it is parked floating
  assign chain_test_reset_b_o      = WIDE ? trst_q : 1'b0;
  assign chain_test_reset_b_oe_n_o = WIDE ? oe_n_f : 1'b1;

endmodule : hspp_host_port

/* logic/hspp_pkg.sv */
/*
  Shared constants and types of the host strobe port.
  Assumes nothing of its surroundings; used by the port module, the access model and the bench.
*/
package hspp_pkg;

  localparam int unsigned NARROW_DATA_W = 16;
  localparam int unsigned WIDE_DATA_W   = 32;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned TCK_DIV_DEF   = 2;
  localparam int unsigned SYNC_STAGES   = 3;

  localparam logic [2:0] SYNC_IDLE_LVL  = 3'h7;

  typedef enum logic [1:0] {
    HSPP_IDLE,
    HSPP_RD_WAIT,
    HSPP_ACK
  } hspp_state_t;

endpackage : hspp_pkg

/* verif/hspp_acc_model.sv */
/*
  Access client model: a small word store behind the acc_* side.
  Assumes the port captures read data at the end of the cycle in which
  acc_rd_o stands.
*/
module hspp_acc_model (
  input  wire logic                          core_clk_i,
  input  wire logic                          acc_wr_o,
  input  wire logic                          acc_rd_o,
  input  wire logic [hspp_pkg::ADDR_W-1:0]   acc_addr_o,
  input  wire logic [15:0]                   acc_wdata_o,
  output logic      [15:0]                   acc_rdata_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [32];
  logic [15:0] filler;
  initial filler = 16'h0000;
  // Filler toggles every cycle so a capture in the wrong cycle shows up
  always @(posedge core_clk_i) begin
    if (acc_wr_o) mem[acc_addr_o] <= acc_wdata_o;
    filler <= ~filler;
  end
  assign acc_rdata_i = acc_rd_o ? mem[acc_addr_o] : filler;
endmodule : hspp_acc_model

/* verif/hspp_host_port_monitor.sv */
/*
  Pin-level checker of the host strobe port.
  Assumes it is bound into every hspp_host_port instance.
*/
module hspp_monitor (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic host_ce_n_i,
  input wire logic host_strobe_n_i,
  input wire logic host_data_oe_n_o,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_oe_n_o,
  input wire logic acc_wr_o,
  input wire logic acc_rd_o,
  input wire logic out_en_n_i,
  input wire logic dev_tdo_oe_n_o,
  input wire logic chain_mode_select_oe_n_o,
  input wire logic chain_data_out_oe_n_o,
  input wire logic chain_out_float_flag_o,
  input wire logic chain_test_clock_o,
  input wire logic scan_tdo_en_i,
  input wire logic scan_tck_rise_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  a_ce_ack_float: assert property (host_ce_n_i |-> transfer_ack_oe_n_o)
    else $error("ack driven while chip enable high");
  a_strobe_data_float: assert property (host_strobe_n_i |-> host_data_oe_n_o)
    else $error("data driven while strobe high");
  a_flag_tracks: assert property (chain_out_float_flag_o ==
    (chain_mode_select_oe_n_o || !$past(scan_tdo_en_i)))
    else $error("float flag disagrees with data out enable");
  a_wr_ack: assert property (acc_wr_o |-> !transfer_ack_n_o ##1 !acc_wr_o)
    else $error("write not acknowledged");
  a_rd_ack: assert property (acc_rd_o |=> !transfer_ack_n_o && !acc_rd_o)
    else $error("read not acknowledged");
  a_oe_float: assert property (out_en_n_i [*7] |-> chain_mode_select_oe_n_o && dev_tdo_oe_n_o)
    else $error("chain outputs driven with output enable high");
  a_tdo_oe_src: assert property (!dev_tdo_oe_n_o |-> !$past(out_en_n_i, 4))
    else $error("test data out driven without output enable low");
  a_tck_rise: assert property ($rose(chain_test_clock_o) |-> $past(scan_tck_rise_o))
    else $error("test clock rose without its pulse");
  a_strobe_sync: assert property (acc_wr_o |-> !$past(host_strobe_n_i, 5))
    else $error("write decoded from a fresh strobe sample");
  a_rst_idle: assert property (disable iff (1'b0)
    !nrst_i |-> transfer_ack_oe_n_o && !acc_wr_o && !acc_rd_o)
    else $error("port active in reset");
  c_wr: cover property (acc_wr_o);
  c_rd: cover property (acc_rd_o);
  c_tck: cover property ($rose(chain_test_clock_o));
endmodule : hspp_monitor

bind hspp_host_port hspp_monitor u_mon (.*);

/* verif/test_host_strobe_port_handshake.sv */
/*
  Self-checking bench of the narrow host strobe port.
  Assumes the checker is bound and the access model stands behind it.
*/
module test_host_strobe_port_handshake;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 0, nrst_i = 1, host_ce_n_i = 1, host_strobe_n_i = 1, host_rw_i = 1;
  logic out_en_n_i = 1, dev_tdo_i = 0, scan_tdo_i = 0, scan_tdo_en_i = 0, scan_tms_i = 1;
  logic scan_trst_i = 0, scan_tck_run_i = 0, chain_data_in_i = 0;
  logic [4:0] host_addr_i = 5'h00, acc_addr_o;
  logic [15:0] host_data_i = 16'h0000, host_data_o, acc_wdata_o, acc_rdata_i;
  logic host_data_oe_n_o, transfer_ack_n_o, transfer_ack_oe_n_o, acc_wr_o, acc_rd_o;
  logic dev_tdo_o, dev_tdo_oe_n_o, scan_tck_rise_o, scan_tdi_o, chain_out_float_flag_o;
  logic chain_data_out_o, chain_data_out_oe_n_o, chain_mode_select_o, chain_mode_select_oe_n_o;
  logic chain_test_clock_o, chain_test_clock_oe_n_o, chain_test_reset_a_o;
  logic chain_test_reset_a_oe_n_o, chain_test_reset_b_o, chain_test_reset_b_oe_n_o;
  int error_cnt = 0, cmp_count = 0, ticks = 0;
  hspp_host_port DUT (.*);
  hspp_acc_model u_acc (.*);
  initial forever #10 core_clk_i = ~core_clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // One strobe cycle; chip enable is left low for the next one
  task automatic cyc(input logic rw, input logic [4:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    int n;
    n = 0;
    @(posedge core_clk_i);
    host_rw_i <= rw;
    host_addr_i <= a;
    host_data_i <= d;
    host_ce_n_i <= 1'b0;
    host_strobe_n_i <= 1'b0;
    @(negedge core_clk_i);
    while (transfer_ack_n_o !== 1'b0 && n < 20) begin
      @(negedge core_clk_i);
      n++;
    end
    r = host_data_o;
    check(transfer_ack_oe_n_o, 0);
    check(host_data_oe_n_o, !rw);
    @(posedge core_clk_i);
    host_strobe_n_i <= 1'b1;
    @(negedge core_clk_i);
    check(host_data_oe_n_o, 1);
    repeat (6) @(negedge core_clk_i);
    check(transfer_ack_oe_n_o, 1);
  endtask : cyc
  task automatic t_bus();
    logic [15:0] r;
    cyc(1'b0, 5'h03, 16'ha5c3, r);
    cyc(1'b0, 5'h1f, 16'h5a3c, r);
    cyc(1'b1, 5'h03, 16'h0000, r);
    check(r, 16'ha5c3);
    cyc(1'b1, 5'h1f, 16'h0000, r);
    check(r, 16'h5a3c);
    // Deselect in the middle of a held read: both drivers must let go at once
    @(posedge core_clk_i);
    host_strobe_n_i <= 1'b0;
    repeat (8) @(negedge core_clk_i);
    check({transfer_ack_n_o, host_data_oe_n_o}, 2'h0);
    @(posedge core_clk_i);
    host_ce_n_i <= 1'b1;
    @(negedge core_clk_i);
    check({transfer_ack_oe_n_o, host_data_oe_n_o}, 2'h3);
    repeat (8) @(negedge core_clk_i);
    check({transfer_ack_oe_n_o, host_data_oe_n_o}, 2'h3);
    @(posedge core_clk_i);
    host_strobe_n_i <= 1'b1;
    $display("t_bus done");
  endtask : t_bus
  task automatic t_chain();
    @(posedge core_clk_i);
    out_en_n_i <= 1'b0;
    scan_tdo_en_i <= 1'b1;
    scan_tdo_i <= 1'b1;
    scan_tms_i <= 1'b0;
    scan_trst_i <= 1'b1;
    dev_tdo_i <= 1'b1;
    chain_data_in_i <= 1'b1;
    repeat (8) @(negedge core_clk_i);
    check({dev_tdo_oe_n_o, chain_out_float_flag_o}, 2'h0);
    check({chain_data_out_o, chain_mode_select_o, chain_test_reset_a_o,
           dev_tdo_o, scan_tdi_o}, 5'h17);
    check({chain_test_reset_b_oe_n_o, chain_test_reset_b_o}, 2'h2);
    @(posedge core_clk_i);
    out_en_n_i <= 1'b1;
    repeat (8) @(negedge core_clk_i);
    check({chain_data_out_oe_n_o, chain_mode_select_oe_n_o, chain_test_clock_oe_n_o,
           chain_test_reset_a_oe_n_o, chain_out_float_flag_o}, 5'h1f);
    $display("t_chain done");
  endtask : t_chain
  task automatic t_tck();
    int k;
    logic p;
    k = 0;
    @(posedge core_clk_i);
    scan_tck_run_i <= 1'b1;
    repeat (8) @(negedge core_clk_i);
    p = chain_test_clock_o;
    repeat (40) begin
      @(negedge core_clk_i);
      if (!p && chain_test_clock_o === 1'b1) k++;
      p = chain_test_clock_o;
    end
    check(k, 40 / (2 * hspp_pkg::TCK_DIV_DEF));
    @(posedge core_clk_i);
    scan_tck_run_i <= 1'b0;
    repeat (6) @(negedge core_clk_i);
    check(chain_test_clock_o, 0);
    $display("t_tck done");
  endtask : t_tck
  // Reset drops with a clock edge; only an asynchronous clear frees the ack in that step
  task automatic t_rst();
    logic [15:0] r;
    @(posedge core_clk_i);
    host_rw_i <= 1'b0;
    host_ce_n_i <= 1'b0;
    host_strobe_n_i <= 1'b0;
    repeat (8) @(negedge core_clk_i);
    check(transfer_ack_oe_n_o, 0);
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    #1 check(transfer_ack_oe_n_o, 1);
    @(posedge core_clk_i);
    host_strobe_n_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (2) @(negedge core_clk_i);
    check({transfer_ack_oe_n_o, acc_wr_o, acc_rd_o}, 3'h4);
    cyc(1'b1, 5'h03, 16'h0000, r);
    check(r, 16'ha5c3);
    $display("t_rst done");
  endtask : t_rst
  always @(posedge core_clk_i) begin
    ticks++;
    if (ticks == 1000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    // A real falling edge lets the asynchronous clear act before the first clock
    nrst_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    t_bus();
    t_chain();
    t_tck();
    t_rst();
    final_report();
  end
endmodule : test_host_strobe_port_handshake
